/* File: hw/dppc_pkg.sv */
// Constants for the downstream port power control block
package dppc_pkg;
  localparam int unsigned DPPC_NUM_PORTS = 6;
  localparam int unsigned DPPC_CLK_MHZ = 125;
  localparam int unsigned DPPC_FILTER_NS = 1000;
  localparam int unsigned DPPC_FILTER_CYC = (DPPC_FILTER_NS * DPPC_CLK_MHZ) / 1000;
  localparam logic DPPC_FLAG_RESET = 1'h0;
endpackage

/* File: hw/dppc_oc_filter.sv */
// Overcurrent glitch filter and sticky change flag for one pin
`timescale 1ns/1ns
`default_nettype none
module dppc_oc_filter
  import dppc_pkg::*;
#(
  parameter int unsigned FILTER_CYC = DPPC_FILTER_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sense_en_i,
  input wire logic pin_low_i,
  input wire logic clear_i,
  output logic oc_o,
  output logic chg_o
);
  localparam int unsigned CW = $clog2(FILTER_CYC + 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic oc_q, oc_d, chg_q, chg_d;

  always_comb begin
    cnt_d = cnt_q;
    oc_d = oc_q;
    chg_d = chg_q;
    if (sense_en_i && pin_low_i) begin
      if (cnt_q != CW'(FILTER_CYC)) begin
        cnt_d = cnt_q + CW'(1);
      end
    end else begin
      cnt_d = '0;
    end
    oc_d = sense_en_i && (cnt_d == CW'(FILTER_CYC));
    if (clear_i) begin
      chg_d = 1'b0;
    end
    if (oc_d != oc_q) begin
      chg_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      oc_q <= 1'b0;
      chg_q <= DPPC_FLAG_RESET;
    end else begin
      cnt_q <= cnt_d;
      oc_q <= oc_d;
      chg_q <= chg_d;
    end
  end

  assign oc_o = oc_q;
  assign chg_o = chg_q;

  AST_OC_NEEDS_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(oc_q) |-> $past(pin_low_i) && $past(sense_en_i))
    else $error("overcurrent rose without a low pin");
  AST_GLITCH_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i)
    (!oc_q && !pin_low_i) ##1 (pin_low_i && sense_en_i) ##1 !pin_low_i |=> !oc_q)
    else $error("one-cycle glitch reported as overcurrent");
  AST_CHG_ON_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
    (oc_q != $past(oc_q)) |-> chg_q)
    else $error("overcurrent change not flagged");
  AST_CHG_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    chg_q && !clear_i |=> chg_q)
    else $error("change flag lost without clear");
  AST_NO_OC_DISABLED: assert property (@(posedge clk_i) disable iff (rst_i)
    !sense_en_i |=> !oc_q)
    else $error("overcurrent while sensing disabled");
  COV_OC: cover property (@(posedge clk_i) disable iff (rst_i) $rose(oc_q));
  COV_CLEAR: cover property (@(posedge clk_i) disable iff (rst_i) chg_q && clear_i);
endmodule
`default_nettype wire

/* File: hw/dppc_top.sv */
// Downstream port power enable and overcurrent sense for six ports
`timescale 1ns/1ns
`default_nettype none
module dppc_top
  import dppc_pkg::*;
#(
  parameter int unsigned NUM_PORTS = DPPC_NUM_PORTS,
  parameter int unsigned FILTER_CYC = DPPC_FILTER_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic GANG_MODE_I,
  input wire logic [NUM_PORTS-1:0] PORT_CFG_EN_I,
  input wire logic [NUM_PORTS-1:0] HOST_PWR_EN_I,
  input wire logic [NUM_PORTS-1:0] OC_CHG_CLR_I,
  input wire logic [NUM_PORTS-1:0] PORT_POWER_OC_PIN_I,
  output logic [NUM_PORTS-1:0] PORT_POWER_OC_PIN_O,
  output logic [NUM_PORTS-1:0] PORT_POWER_OC_PIN_OE_O,
  output logic [NUM_PORTS-1:0] PORT_POWER_OC_PIN_PU_O,
  input wire logic SHARED_POWER_OC_PIN_I,
  output logic SHARED_POWER_OC_PIN_O,
  output logic SHARED_POWER_OC_PIN_OE_O,
  output logic SHARED_POWER_OC_PIN_PU_O,
  output logic [NUM_PORTS-1:0] PORT_OC_O,
  output logic [NUM_PORTS-1:0] PORT_OC_CHG_O
);
  logic [NUM_PORTS-1:0] en_q, en_d;
  logic gang_q, gang_d;
  logic gang_en;
  localparam int unsigned RUN_W = $clog2(FILTER_CYC + 1);
  logic gang_oc, gang_chg;
  logic [NUM_PORTS-1:0] ind_oc, ind_chg;
  logic [RUN_W-1:0] gang_run_q, gang_run_d;

  always_comb begin
    en_d = PORT_CFG_EN_I & HOST_PWR_EN_I;
    gang_d = GANG_MODE_I;
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      en_q <= '0;
      gang_q <= 1'b0;
    end else begin
      en_q <= en_d;
      gang_q <= gang_d;
    end
  end

  assign gang_en = gang_q && (|en_q);

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      logic sense_en;
      assign sense_en = !gang_q && en_q[g];
      // Open drain: released with pull-up while enabled outside ganged mode, driven low otherwise
      assign PORT_POWER_OC_PIN_O[g] = 1'b0;
      assign PORT_POWER_OC_PIN_OE_O[g] = !sense_en;
      assign PORT_POWER_OC_PIN_PU_O[g] = sense_en;
      dppc_oc_filter #(.FILTER_CYC(FILTER_CYC)) u_filt (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .sense_en_i(sense_en),
        .pin_low_i(!PORT_POWER_OC_PIN_I[g]),
        .clear_i(OC_CHG_CLR_I[g]),
        .oc_o(ind_oc[g]),
        .chg_o(ind_chg[g])
      );

      // Reference count of consecutive low samples while sensing
      logic [RUN_W-1:0] low_run_q, low_run_d;
      always_comb begin
        low_run_d = '0;
        if (sense_en && !PORT_POWER_OC_PIN_I[g]) begin
          low_run_d = low_run_q;
          if (low_run_q != RUN_W'(FILTER_CYC)) begin
            low_run_d = low_run_q + RUN_W'(1);
          end
        end
      end

      always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
          low_run_q <= '0;
        end else begin
          low_run_q <= low_run_d;
        end
      end

      AST_PORT_PU_EN: assert property (@(posedge CLK_I) disable iff (RST_I)
        (!gang_q && en_q[g]) |-> PORT_POWER_OC_PIN_PU_O[g])
        else $error("enabled port pin has no pull-up");
      AST_PORT_OE_EN: assert property (@(posedge CLK_I) disable iff (RST_I)
        (!gang_q && en_q[g]) |-> !PORT_POWER_OC_PIN_OE_O[g])
        else $error("enabled port pin still driven");
      AST_PORT_DRIVE_LOW: assert property (@(posedge CLK_I) disable iff (RST_I)
        !en_q[g] |-> PORT_POWER_OC_PIN_OE_O[g] && !PORT_POWER_OC_PIN_O[g])
        else $error("disabled port pin not driven low");
      AST_PORT_NO_PU_OFF: assert property (@(posedge CLK_I) disable iff (RST_I)
        !en_q[g] |-> !PORT_POWER_OC_PIN_PU_O[g])
        else $error("pull-up on while port disabled");
      AST_PORT_CFG_OFF: assert property (@(posedge CLK_I) disable iff (RST_I)
        !PORT_CFG_EN_I[g] |=> PORT_POWER_OC_PIN_OE_O[g])
        else $error("port kept power after configuration disable");
      AST_PORT_HOST_OFF: assert property (@(posedge CLK_I) disable iff (RST_I)
        !HOST_PWR_EN_I[g] |=> PORT_POWER_OC_PIN_OE_O[g])
        else $error("port kept power after host disable");
      AST_PORT_PIN_LOW_ONLY: assert property (@(posedge CLK_I) disable iff (RST_I)
        !PORT_POWER_OC_PIN_O[g])
        else $error("port pin driven high");
      AST_PORT_OC_MIRROR: assert property (@(posedge CLK_I) disable iff (RST_I)
        !gang_q |-> (PORT_OC_O[g] == ind_oc[g]) && (PORT_OC_CHG_O[g] == ind_chg[g]))
        else $error("port status not from its own filter");
      AST_PORT_GANG_MIRROR: assert property (@(posedge CLK_I) disable iff (RST_I)
        gang_q |-> (PORT_OC_O[g] == (gang_oc && en_q[g]))
          && (PORT_OC_CHG_O[g] == (gang_chg && en_q[g])))
        else $error("port status not from shared filter");
      AST_PORT_NO_OC_OFF: assert property (@(posedge CLK_I) disable iff (RST_I)
        !en_q[g] ##1 !en_q[g] |-> !PORT_OC_O[g])
        else $error("overcurrent reported on disabled port");
      AST_PORT_OC_NEEDS_RUN: assert property (@(posedge CLK_I) disable iff (RST_I)
        (!gang_q && PORT_OC_O[g]) |-> low_run_q == RUN_W'(FILTER_CYC))
        else $error("overcurrent without a full low run");
      AST_PORT_RUN_GIVES_OC: assert property (@(posedge CLK_I) disable iff (RST_I)
        (!gang_q && (low_run_q == RUN_W'(FILTER_CYC))) |-> PORT_OC_O[g])
        else $error("full low run not reported");
    end
  endgenerate

  dppc_oc_filter #(.FILTER_CYC(FILTER_CYC)) u_gang_filt (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .sense_en_i(gang_en),
    .pin_low_i(!SHARED_POWER_OC_PIN_I),
    .clear_i(&(OC_CHG_CLR_I | ~en_q)),
    .oc_o(gang_oc),
    .chg_o(gang_chg)
  );

  // Reference count of consecutive low samples on the shared pin
  always_comb begin
    gang_run_d = '0;
    if (gang_en && !SHARED_POWER_OC_PIN_I) begin
      gang_run_d = gang_run_q;
      if (gang_run_q != RUN_W'(FILTER_CYC)) begin
        gang_run_d = gang_run_q + RUN_W'(1);
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gang_run_q <= '0;
    end else begin
      gang_run_q <= gang_run_d;
    end
  end

  assign SHARED_POWER_OC_PIN_O = 1'b0;
  assign SHARED_POWER_OC_PIN_OE_O = !gang_en;
  assign SHARED_POWER_OC_PIN_PU_O = gang_en;

  assign PORT_OC_O = gang_q ? ({NUM_PORTS{gang_oc}} & en_q) : ind_oc;
  assign PORT_OC_CHG_O = gang_q ? ({NUM_PORTS{gang_chg}} & en_q) : ind_chg;

  AST_GANG_PU: assert property (@(posedge CLK_I) disable iff (RST_I)
    gang_en |-> SHARED_POWER_OC_PIN_PU_O && !SHARED_POWER_OC_PIN_OE_O)
    else $error("shared pin not released with pull-up");
  AST_GANG_DRIVE_LOW: assert property (@(posedge CLK_I) disable iff (RST_I)
    !gang_en |-> SHARED_POWER_OC_PIN_OE_O && !SHARED_POWER_OC_PIN_PU_O
      && !SHARED_POWER_OC_PIN_O)
    else $error("idle shared pin not driven low");
  AST_GANG_NEXT: assert property (@(posedge CLK_I) disable iff (RST_I)
    GANG_MODE_I && (|(PORT_CFG_EN_I & HOST_PWR_EN_I)) |=> SHARED_POWER_OC_PIN_PU_O)
    else $error("shared pin not released in ganged mode");
  AST_SOLO_SHARED_OFF: assert property (@(posedge CLK_I) disable iff (RST_I)
    !GANG_MODE_I |=> SHARED_POWER_OC_PIN_OE_O)
    else $error("shared pin released outside ganged mode");
  AST_GANG_NO_OC_IDLE: assert property (@(posedge CLK_I) disable iff (RST_I)
    !gang_en ##1 !gang_en |-> !gang_oc)
    else $error("shared overcurrent while shared pin idle");
  AST_GANG_OC_NEEDS_RUN: assert property (@(posedge CLK_I) disable iff (RST_I)
    gang_oc |-> gang_run_q == RUN_W'(FILTER_CYC))
    else $error("shared overcurrent without a full low run");
  AST_GANG_RUN_GIVES_OC: assert property (@(posedge CLK_I) disable iff (RST_I)
    (gang_run_q == RUN_W'(FILTER_CYC)) |-> gang_oc)
    else $error("full shared low run not reported");

  AST_EN_RELEASE: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!gang_q && en_q[0]) |-> PORT_POWER_OC_PIN_PU_O[0] && !PORT_POWER_OC_PIN_OE_O[0])
    else $error("enabled port pin not released with pull-up");
  AST_DIS_DRIVE_LOW: assert property (@(posedge CLK_I) disable iff (RST_I)
    !(PORT_CFG_EN_I[0] && HOST_PWR_EN_I[0]) |=> PORT_POWER_OC_PIN_OE_O[0]
      && !PORT_POWER_OC_PIN_O[0])
    else $error("disabled port pin not driven low");
  AST_GANG_PINS_OFF: assert property (@(posedge CLK_I) disable iff (RST_I)
    gang_q |-> &PORT_POWER_OC_PIN_OE_O)
    else $error("per-port pin released in ganged mode");
  AST_EN_TRACK: assert property (@(posedge CLK_I) disable iff (RST_I)
    (PORT_CFG_EN_I[NUM_PORTS-1] && HOST_PWR_EN_I[NUM_PORTS-1] && !GANG_MODE_I)
      |=> PORT_POWER_OC_PIN_PU_O[NUM_PORTS-1])
    else $error("last port does not follow its enable");
  COV_GANG: cover property (@(posedge CLK_I) disable iff (RST_I) gang_en && gang_oc);
  COV_PORT_OC: cover property (@(posedge CLK_I) disable iff (RST_I) |ind_oc);
  COV_DISABLE: cover property (@(posedge CLK_I) disable iff (RST_I) $fell(en_q[0]));
endmodule
`default_nettype wire

/* File: tb/dppc_mon_model.sv */
// Current monitor and power switch model on one or more power pins
`timescale 1ns/1ns
`default_nettype none
module dppc_mon_model #(
  parameter int W = 6
) (
  input wire logic clk_i,
  input wire logic [W-1:0] oc_req_i,
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] pu_i,
  output logic [W-1:0] line_o
);
  logic [W-1:0] flip_q = '0;
  always_ff @(posedge clk_i) begin
    flip_q <= ~flip_q;
  end
  // Pulls low on overcurrent or while driven (oe_i), else released to pull-up or floating
  assign line_o = ~(oe_i | oc_req_i) & (pu_i | flip_q);
endmodule
`default_nettype wire

/* File: tb/tb_dppc_top.sv */
// Testbench for the port power control block
`timescale 1ns/1ns
`default_nettype none
module tb_dppc_top;
  logic clk = 1'h0, rst = 1'h1, gang = 1'h0, soc = 1'h0, spin, soe, spu;
  logic [5:0] cfg = '0, host = '0, clr = '0, oc = '0, pin, oe, pu, poc, chg, pdrv;
  logic sdrv;
  int num_errors = 0, checks = 0;
  initial forever #4 clk = ~clk;
  dppc_mon_model #(.W(6)) i_dppc_mon_model (.clk_i(clk), .oc_req_i(oc), .oe_i(oe), .pu_i(pu),
    .line_o(pin));
  dppc_mon_model #(.W(1)) i_dppc_mon_model_1 (.clk_i(clk), .oc_req_i(soc), .oe_i(soe),
    .pu_i(spu), .line_o(spin));
  dppc_top #(.FILTER_CYC(3)) i_dppc_top (.CLK_I(clk), .RST_I(rst), .GANG_MODE_I(gang),
    .PORT_CFG_EN_I(cfg), .HOST_PWR_EN_I(host), .OC_CHG_CLR_I(clr), .PORT_POWER_OC_PIN_I(pin),
    .PORT_POWER_OC_PIN_O(pdrv), .PORT_POWER_OC_PIN_OE_O(oe), .PORT_POWER_OC_PIN_PU_O(pu),
    .SHARED_POWER_OC_PIN_I(spin), .SHARED_POWER_OC_PIN_O(sdrv), .SHARED_POWER_OC_PIN_OE_O(soe),
    .SHARED_POWER_OC_PIN_PU_O(spu), .PORT_OC_O(poc), .PORT_OC_CHG_O(chg));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_enable;
    @(posedge clk);
    cfg <= 6'h3f;
    host <= 6'h3f;
    cyc(2);
    chk(pu, 6'h3f);
    chk(oe, 6'h00);
    chk(pin, 6'h3f);
    @(posedge clk);
    oc <= 6'h01;
    repeat (2) @(posedge clk);
    oc <= '0;
    cyc(6);
    chk(poc | chg, 6'h00);
    @(posedge clk);
    oc <= 6'h02;
    @(posedge clk);
    oc <= '0;
    cyc(4);
    chk(poc | chg, 6'h00);
    $display("test enable and glitch done");
  endtask
  task automatic t_oc;
    @(posedge clk);
    oc <= 6'h04;
    cyc(6);
    chk(poc, 6'h04);
    chk(chg, 6'h04);
    @(posedge clk);
    oc <= '0;
    cyc(2);
    chk(poc, 6'h00);
    chk(chg, 6'h04);
    @(posedge clk);
    clr <= 6'h04;
    @(posedge clk);
    clr <= '0;
    cyc(1);
    chk(chg, 6'h00);
    $display("test overcurrent done");
  endtask
  task automatic t_disable;
    @(posedge clk);
    host <= 6'h3d;
    cfg <= 6'h2f;
    oc <= 6'h12;
    cyc(6);
    chk(oe, 6'h12);
    chk(pu, 6'h2d);
    chk(pin & 6'h12, 6'h00);
    chk(pdrv, 6'h00);
    chk(poc | chg, 6'h00);
    @(posedge clk);
    oc <= '0;
    host <= 6'h3f;
    cfg <= 6'h3f;
    $display("test disable done");
  endtask
  task automatic t_gang;
    @(posedge clk);
    gang <= 1'h1;
    cyc(3);
    chk({5'h00, spu}, 6'h01);
    chk({5'h00, soe | sdrv}, 6'h00);
    chk(oe, 6'h3f);
    @(posedge clk);
    soc <= 1'h1;
    cyc(6);
    chk(poc, 6'h3f);
    chk(chg, 6'h3f);
    @(posedge clk);
    soc <= 1'h0;
    cyc(2);
    chk(poc, 6'h00);
    chk(chg, 6'h3f);
    @(posedge clk);
    clr <= 6'h3f;
    @(posedge clk);
    clr <= '0;
    cyc(1);
    chk(poc | chg, 6'h00);
    $display("test gang done");
  endtask
  initial begin
    cyc(3);
    chk(oe, 6'h3f);
    chk(pu | poc | chg, 6'h00);
    chk({5'h00, soe}, 6'h01);
    @(posedge clk);
    rst <= 1'h0;
    t_enable();
    t_oc();
    t_disable();
    t_gang();
    complete_run();
  end
  initial begin
    #5000;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
